// ### core/pmsc_pkg.sv
package pmsc_pkg;
    // =====================================================
    // widths and timing
    // =====================================================
    // number of optical channels
    localparam int NUM_CHANNELS = 4;
    // clock period in picoseconds (200 MHz)
    localparam int CLK_PERIOD_PS = 5000;
    // power-on initialization limit in milliseconds
    localparam int INIT_TIME_MS = 2000;
    // longest time: rounds down to whole cycles
    localparam longint INIT_CYCLES =
        (longint'(INIT_TIME_MS) * 64'd1000000000) / CLK_PERIOD_PS;
    // default minimum qualifying reset low time, nanoseconds
    localparam int RESET_MIN_NS = 100;
    // least time: rounds up to whole cycles
    localparam int RESET_MIN_CYCLES =
        (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // =====================================================
    // reset values
    // =====================================================
    localparam logic [3:0] CHAN_ENABLE_RESET = 4'h0;
    localparam logic POWER_CLASS_RESET = 1'b1;
    // =====================================================
    // types
    // =====================================================
    // module life cycle
    typedef enum logic [1:0] {
        PMSC_INIT = 2'b00,
        PMSC_READY = 2'b01,
        PMSC_IN_RESET = 2'b10
    } pmsc_state_t;
    // settings restored on reset
    typedef struct packed {
        logic [3:0] chan_enable;
        logic high_power_allowed;
    } pmsc_settings_t;
    // sideband pins as seen by the module
    typedef struct packed {
        logic module_select_n;
        logic module_reset_n;
        logic low_power_select;
    } pmsc_pins_t;
endpackage : pmsc_pkg

// ### core/pmsc_sync3.sv
`timescale 1ns/1ps
module pmsc_sync3 #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_value,
    output logic [WIDTH-1:0] sync_out
);
    // =====================================================
    // three-stage sampler with agreement filter
    // =====================================================
    // first stage, read only by second stage
    logic [WIDTH-1:0] meta;
    // second and third stages
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // shift chain, constants under reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= '1;
            stage2 <= '1;
            stage3 <= '1;
        end else begin
            meta <= async_in;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    // accept a change once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync_out[i] <= 1'b1;
                end else if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    endgenerate
    // reset_value kept for width symmetry; unused levels read high
    logic unused_ok;
    assign unused_ok = ^reset_value;
endmodule : pmsc_sync3

// ### core/pmsc_sideband.sv
`timescale 1ns/1ps
// Summary of operation
// - answer serial bus only while selected
// - qualified reset low restores default settings
// - completion: interrupt low, not-ready negated
// - post completion interrupt after power-up
// - low-power input caps power class
// - presence line tied to ground
// - interrupt low flags fault or status
// - interrupt only pulls low or floats
// - fully functional within 2000 ms
// - four channels individually shut down
// - serial interface reaches memory map
module pmsc_sideband #(
    parameter int NUM_CHANNELS = pmsc_pkg::NUM_CHANNELS,
    parameter longint INIT_CYCLES = pmsc_pkg::INIT_CYCLES,
    parameter int RESET_MIN_CYCLES = pmsc_pkg::RESET_MIN_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_select,
    output logic module_present_n,
    output logic module_interrupt_n_drive,
    output logic module_interrupt_n_oe_n,
    input wire logic fault_event,
    input wire logic interrupt_clear,
    input wire logic map_write,
    input wire logic [NUM_CHANNELS-1:0] map_chan_enable,
    output logic serial_bus_enable,
    output logic data_not_ready,
    output logic [NUM_CHANNELS-1:0] chan_enable,
    output logic high_power_enable,
    output logic module_functional
);
    // =====================================================
    // pin sampling
    // =====================================================
    // raw and filtered pin levels
    pmsc_pkg::pmsc_pins_t pins_raw;
    pmsc_pkg::pmsc_pins_t pins;
    assign pins_raw.module_select_n = module_select_n;
    assign pins_raw.module_reset_n = module_reset_n;
    assign pins_raw.low_power_select = low_power_select;

    // four flops per pin, change taken when stages two and three agree
    pmsc_sync3 #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(pins_raw),
        .reset_value(3'h7),
        .sync_out(pins)
    );

    // =====================================================
    // reset pulse qualification
    // =====================================================
    // low-time counter, saturating
    logic [31:0] low_count;
    // pulse qualified and still held
    logic reset_qualified;
    // reset pin released this cycle after qualification
    logic reset_release;

    // count cycles the filtered reset pin stays low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_count <= 32'h0000_0000;
        end else if (pins.module_reset_n) begin
            low_count <= 32'h0000_0000;
        end else if (low_count != 32'hFFFF_FFFF) begin
            low_count <= low_count + 32'h0000_0001;
        end
    end

    assign reset_qualified = !pins.module_reset_n &&
        (low_count >= 32'(RESET_MIN_CYCLES - 1));

    // =====================================================
    // life-cycle state machine
    // =====================================================
    pmsc_pkg::pmsc_state_t state;
    pmsc_pkg::pmsc_state_t next_state;
    // power-on initialization counter
    logic [39:0] init_count;
    logic init_done;
    assign init_done = (init_count >= 40'(INIT_CYCLES - 1));
    assign reset_release = (state == pmsc_pkg::PMSC_IN_RESET) &&
        pins.module_reset_n;

    // next-state selection
    always_comb begin
        next_state = state;
        case (state)
            pmsc_pkg::PMSC_INIT: begin
                if (reset_qualified) begin
                    next_state = pmsc_pkg::PMSC_IN_RESET;
                end else if (init_done) begin
                    next_state = pmsc_pkg::PMSC_READY;
                end
            end
            // normal operation
            pmsc_pkg::PMSC_READY: begin
                if (reset_qualified) begin
                    next_state = pmsc_pkg::PMSC_IN_RESET;
                end
            end
            // wait for the reset pin to rise
            pmsc_pkg::PMSC_IN_RESET: begin
                if (pins.module_reset_n) begin
                    next_state = pmsc_pkg::PMSC_INIT;
                end
            end
            default: begin
                next_state = pmsc_pkg::PMSC_INIT;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= pmsc_pkg::PMSC_INIT;
        end else begin
            state <= next_state;
        end
    end

    // init counter runs only in the init state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            init_count <= 40'h00_0000_0000;
        end else if (state != pmsc_pkg::PMSC_INIT) begin
            init_count <= 40'h00_0000_0000;
        end else if (!init_done) begin
            init_count <= init_count + 40'h00_0000_0001;
        end
    end

    // =====================================================
    // module settings
    // =====================================================
    pmsc_pkg::pmsc_settings_t settings;

    // channel enables from map writes, defaults on reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settings.chan_enable <= pmsc_pkg::CHAN_ENABLE_RESET;
        end else if (state == pmsc_pkg::PMSC_IN_RESET) begin
            settings.chan_enable <= pmsc_pkg::CHAN_ENABLE_RESET;
        end else if (map_write && serial_bus_enable) begin
            settings.chan_enable <= map_chan_enable;
        end
    end

    // power class follows the low-power input
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settings.high_power_allowed <= !pmsc_pkg::POWER_CLASS_RESET;
        end else begin
            settings.high_power_allowed <= !pins.low_power_select &&
                (state == pmsc_pkg::PMSC_READY);
        end
    end

    assign chan_enable = settings.chan_enable;
    assign high_power_enable = settings.high_power_allowed;
    assign module_functional = (state == pmsc_pkg::PMSC_READY);

    // =====================================================
    // serial bus gating
    // =====================================================
    // respond only while selected
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            serial_bus_enable <= 1'b0;
        end else begin
            serial_bus_enable <= !pins.module_select_n &&
                (state == pmsc_pkg::PMSC_READY);
        end
    end

    // =====================================================
    // data-not-ready and interrupt
    // =====================================================
    // pending interrupt latch
    logic int_pending;

    // not-ready high until init finishes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_not_ready <= 1'b1;
        end else begin
            data_not_ready <= (next_state != pmsc_pkg::PMSC_READY);
        end
    end

    // set wins over map-side clear; completion posts on every entry to ready
    // a qualified module reset drops the flag on the same edge that
    // raises not-ready, so the line never shows low with not-ready set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_pending <= 1'b0;
        end else if (next_state == pmsc_pkg::PMSC_IN_RESET ||
                     reset_release) begin
            int_pending <= 1'b0;
        end else if (state == pmsc_pkg::PMSC_INIT &&
                     next_state == pmsc_pkg::PMSC_READY) begin
            int_pending <= 1'b1;
        end else if (fault_event && state == pmsc_pkg::PMSC_READY) begin
            int_pending <= 1'b1;
        // map-side clear loses against a set in the same cycle
        end else if (interrupt_clear) begin
            int_pending <= 1'b0;
        end
    end

    assign module_interrupt_n_drive = 1'b0;
    assign module_interrupt_n_oe_n = !int_pending;

    assign module_present_n = 1'b0;
endmodule : pmsc_sideband

// ### verification/pmsc_sideband_chk.sv
`timescale 1ns/1ps
module pmsc_sideband_chk #(
    parameter int NUM_CHANNELS = pmsc_pkg::NUM_CHANNELS,
    parameter longint INIT_CYCLES = pmsc_pkg::INIT_CYCLES,
    parameter int RESET_MIN_CYCLES = pmsc_pkg::RESET_MIN_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_select,
    input wire logic module_present_n,
    input wire logic module_interrupt_n_drive,
    input wire logic module_interrupt_n_oe_n,
    input wire logic fault_event,
    input wire logic interrupt_clear,
    input wire logic map_write,
    input wire logic [NUM_CHANNELS-1:0] map_chan_enable,
    input wire logic serial_bus_enable,
    input wire logic data_not_ready,
    input wire logic [NUM_CHANNELS-1:0] chan_enable,
    input wire logic high_power_enable,
    input wire logic module_functional
);
    // =====================================================
    // helper counters
    // =====================================================
    // cycles spent waiting for readiness with the reset pin high
    longint wait_cnt;
    // consecutive low cycles of the reset pin
    int low_cnt;
    // wait counter restarts when ready or while the pin holds reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt <= 0;
        end else if (module_functional || !module_reset_n) begin
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
    // low counter saturates so it never wraps
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt <= 0;
        end else if (module_reset_n) begin
            low_cnt <= 0;
        end else if (low_cnt < 255) begin
            low_cnt <= low_cnt + 1;
        end
    end
    // =====================================================
    // properties
    // =====================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // module has just become ready
    sequence s_enter_ready;
        $rose(module_functional);
    endsequence
    // a pin reset pulse too short to qualify
    sequence s_short_pulse;
        $rose(module_reset_n) && low_cnt < 8 && module_functional;
    endsequence
    chk_post_ready: assert property (
        s_enter_ready |=> !module_interrupt_n_oe_n)
        else $error("no interrupt after becoming ready");
    chk_int_not_ready: assert property (
        !module_interrupt_n_oe_n |-> !data_not_ready)
        else $error("interrupt while data not ready");
    chk_short_ignored: assert property (
        s_short_pulse |=> module_functional [*8])
        else $error("short reset pulse was taken");
    chk_pin_reset: assert property (
        low_cnt == RESET_MIN_CYCLES + 8 |-> chan_enable == '0
        && data_not_ready && module_interrupt_n_oe_n && !high_power_enable)
        else $error("qualified reset kept settings");
    chk_select_gate: assert property (
        module_select_n [*8] |-> !serial_bus_enable)
        else $error("bus enabled while deselected");
    chk_map_write: assert property (
        map_write && serial_bus_enable && module_functional
        |=> chan_enable == $past(map_chan_enable))
        else $error("channel enables not written");
    chk_low_power: assert property (
        low_power_select [*8] |-> !high_power_enable)
        else $error("high power allowed in low power mode");
    chk_fault_int: assert property (
        fault_event && module_functional |=> !module_interrupt_n_oe_n)
        else $error("fault did not raise interrupt");
    chk_pins_tied: assert property (
        !module_present_n && !module_interrupt_n_drive)
        else $error("presence or interrupt drive not low");
    chk_init_bound: assert property (
        wait_cnt <= INIT_CYCLES + 8)
        else $error("initialization took too long");
endmodule : pmsc_sideband_chk

bind pmsc_sideband pmsc_sideband_chk #(.NUM_CHANNELS(NUM_CHANNELS),
    .INIT_CYCLES(INIT_CYCLES), .RESET_MIN_CYCLES(RESET_MIN_CYCLES)
) i_pmsc_sideband_chk (
    .clk(clk),
    .resetn(resetn),
    .module_select_n(module_select_n),
    .module_reset_n(module_reset_n),
    .low_power_select(low_power_select),
    .module_present_n(module_present_n),
    .module_interrupt_n_drive(module_interrupt_n_drive),
    .module_interrupt_n_oe_n(module_interrupt_n_oe_n),
    .fault_event(fault_event),
    .interrupt_clear(interrupt_clear),
    .map_write(map_write),
    .map_chan_enable(map_chan_enable),
    .serial_bus_enable(serial_bus_enable),
    .data_not_ready(data_not_ready),
    .chan_enable(chan_enable),
    .high_power_enable(high_power_enable),
    .module_functional(module_functional)
);

// ### verification/pmsc_host_model.sv
`timescale 1ns/1ps
// host board side: pull-ups and line resolution
module pmsc_host_model (
    input wire logic oe_n,
    input wire logic drive_o,
    input wire logic present_n,
    output logic int_line,
    output logic present_line
);
    assign int_line = oe_n ? 1'h1 : drive_o;
    assign present_line = present_n ? 1'h1 : 1'h0;
endmodule : pmsc_host_model

// ### verification/test_pmsc_sideband.sv
`timescale 1ns/1ps
module test_pmsc_sideband;
    // short counts keep the run brief
    localparam longint INIT_N = 50;
    localparam int RMIN_N = 20;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    // host pins, one dedicated select line per module
    logic sel_n = 1'h1, rst_n = 1'h1, lp = 1'h0;
    logic fault = 1'h0, iclr = 1'h0, mw = 1'h0;
    logic [3:0] mdata = 4'h0;
    logic [3:0] exp_chan = 4'h0;
    logic present_n, int_o, int_oe_n, sbe, dnr, hpe, func;
    logic [3:0] chan;
    logic int_line, present_line;
    int n_mismatch = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    pmsc_sideband #(.INIT_CYCLES(INIT_N), .RESET_MIN_CYCLES(RMIN_N))
    i_pmsc_sideband (.clk(clk), .resetn(resetn), .module_select_n(sel_n),
        .module_reset_n(rst_n), .low_power_select(lp),
        .module_present_n(present_n), .module_interrupt_n_drive(int_o),
        .module_interrupt_n_oe_n(int_oe_n), .fault_event(fault),
        .interrupt_clear(iclr), .map_write(mw), .map_chan_enable(mdata),
        .serial_bus_enable(sbe), .data_not_ready(dnr), .chan_enable(chan),
        .high_power_enable(hpe), .module_functional(func));
    pmsc_host_model i_pmsc_host_model (.oe_n(int_oe_n), .drive_o(int_o),
        .present_n(present_n), .int_line(int_line),
        .present_line(present_line));
    // expected power class when ready
    function automatic logic exp_hp(input logic lowp);
        return !lowp;
    endfunction : exp_hp
    // compares and counts one value
    task automatic chk(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    // bounded wait for the interrupt line to fall
    task automatic wait_int(input int limit);
        int i;
        i = 0;
        while (int_line !== 1'h0 && i < limit) begin
            @(negedge clk);
            i++;
        end
        if (int_line !== 1'h0) begin
            n_mismatch++;
            $display("CHECK FAILED interrupt_wait expected 0 seen %h",
                int_line);
            end_of_test();
        end
    endtask : wait_int
    initial begin
        void'($urandom(32'h8f11));
        step(8);
        resetn <= 1'h1;
        wait_int(INIT_N + 20);
        chk("not_ready", dnr, 0);
        chk("functional", func, 1);
        chk("present", present_line, 0);
        step(1);
        iclr <= 1'h1;
        step(1);
        iclr <= 1'h0;
        @(negedge clk);
        chk("int_released", int_line, 1);
        $display("test power_up done");
        step(1);
        sel_n <= 1'h0;
        step(8);
        // random channel writes with random power mode
        for (int k = 0; k < 16; k++) begin
            mdata <= 4'($urandom);
            lp <= 1'($urandom);
            mw <= 1'h1;
            step(1);
            mw <= 1'h0;
            exp_chan = mdata;
            step(7);
            @(negedge clk);
            chk("chan_enable", chan, exp_chan);
            chk("high_power", hpe, exp_hp(lp));
            chk("bus_enable", sbe, 1);
            step(1);
        end
        $display("test map_writes done");
        sel_n <= 1'h1;
        step(8);
        mdata <= ~exp_chan;
        mw <= 1'h1;
        step(1);
        mw <= 1'h0;
        step(2);
        @(negedge clk);
        chk("refused", chan, exp_chan);
        chk("bus_off", sbe, 0);
        $display("test deselected done");
        step(1);
        fault <= 1'h1;
        step(1);
        fault <= 1'h0;
        @(negedge clk);
        chk("fault_int", int_line, 0);
        // host pulses the map-side clear, then sees the line released
        step(1);
        iclr <= 1'h1;
        step(1);
        iclr <= 1'h0;
        @(negedge clk);
        chk("fault_cleared", int_line, 1);
        // set and clear in one cycle: the set wins
        step(1);
        fault <= 1'h1;
        iclr <= 1'h1;
        step(1);
        fault <= 1'h0;
        iclr <= 1'h0;
        @(negedge clk);
        chk("set_wins", int_line, 0);
        step(1);
        iclr <= 1'h1;
        step(1);
        iclr <= 1'h0;
        @(negedge clk);
        chk("set_cleared", int_line, 1);
        $display("test fault done");
        step(1);
        rst_n <= 1'h0;
        step(5);
        rst_n <= 1'h1;
        step(12);
        @(negedge clk);
        chk("short_func", func, 1);
        chk("short_chan", chan, exp_chan);
        $display("test short_pulse done");
        step(1);
        rst_n <= 1'h0;
        step(RMIN_N + 12);
        @(negedge clk);
        chk("reset_chan", chan, 0);
        chk("reset_not_ready", dnr, 1);
        chk("reset_int", int_line, 1);
        step(1);
        rst_n <= 1'h1;
        // status read only after the completion interrupt
        wait_int(INIT_N + 20);
        chk("reset_done", dnr, 0);
        $display("test pin_reset done");
        end_of_test();
    end
endmodule : test_pmsc_sideband
